// ===== test/gate_drive_assertions.sv
`timescale 1ns/1ps
module gate_drive_assertions (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Watched ports
  input wire logic       scl,
  input wire logic       sda_oe_b,
  input wire logic       reg_reset,
  input wire logic [7:0] charge_current,
  input wire logic       battery_below_min,
  input wire logic [7:0] end_of_charge_current,
  input wire logic [7:0] precharge_limit,
  input wire logic [2:0] high_side_two_strength,
  input wire logic [2:0] low_side_two_strength,
  input wire logic       system_loop_slowdown,
  input wire logic [7:0] applied_precharge_current
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_rst_vals;
    $rose(rst_b) |-> {high_side_two_strength, low_side_two_strength,
      system_loop_slowdown} == 7'h36 && end_of_charge_current == 8'h20
      && precharge_limit == 8'h30;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset value");
  property p_apply;
    battery_below_min |=> applied_precharge_current ==
      ($past(charge_current) < $past(precharge_limit) ?
       $past(charge_current) : $past(precharge_limit));
  endproperty
  a_apply: assert property (p_apply) else $error("precharge min");
  property p_apply_off;
    !battery_below_min |=> applied_precharge_current == 8'h00;
  endproperty
  a_apply_off: assert property (p_apply_off) else $error("precharge off");
  property p_reg_reset;
    reg_reset |=> precharge_limit == 8'h30;
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("clamp reset");
  property p_eoc_range;
    end_of_charge_current inside {[8'h10:8'hfc]};
  endproperty
  a_eoc_range: assert property (p_eoc_range) else $error("term range");
  property p_pl_range;
    precharge_limit inside {[8'h10:8'hfc]};
  endproperty
  a_pl_range: assert property (p_pl_range) else $error("clamp range");
  property p_oe_hold;
    scl && $past(scl) |-> $stable(sda_oe_b);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data in scl high");
  property p_set_time;
    $changed(high_side_two_strength) || $changed(system_loop_slowdown)
      |-> !scl && !$past(scl);
  endproperty
  a_set_time: assert property (p_set_time) else $error("drive change");
endmodule

bind charge_profile_gate_drive_regs gate_drive_assertions u_chk (
  .sys_clk, .rst_b, .scl, .sda_oe_b, .reg_reset, .charge_current,
  .battery_below_min, .end_of_charge_current, .precharge_limit,
  .high_side_two_strength, .low_side_two_strength, .system_loop_slowdown,
  .applied_precharge_current
);

// ===== test/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
  parameter bit LOW_OHM_SENSE_SELECT = 1'b0
) (
  // Bus
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv,
  output logic      nak
);
  import charge_profile_pkg::*;
  logic r;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    nak = 1'b0;
  end
  // ==========
  // One bit, sda moved only while scl is low
  task automatic bit_io(input logic b, output logic v);
    @(posedge sys_clk) sda_drv <= b;
    repeat (3) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) v = sda;
    @(posedge sys_clk) scl <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic edge_cond(input logic last_sda);
    @(posedge sys_clk) sda_drv <= !last_sda;
    repeat (3) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_drv <= last_sda;
    repeat (4) @(posedge sys_clk);
    if (!last_sda) begin
      scl <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    nak = nak | r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d);
    nak = 1'b0;
    if (LOW_OHM_SENSE_SELECT && p == 8'h11 && d > 8'h66) begin
      d = 8'h66;
    end
    edge_cond(1'b0);
    send({a, 1'b0});
    send(p);
    send(d);
    edge_cond(1'b1);
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    nak = 1'b0;
    edge_cond(1'b0);
    send({DEVICE_ADDR, 1'b0});
    send(p);
    edge_cond(1'b0);
    send({DEVICE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    edge_cond(1'b1);
  endtask
  // Two-byte read: master ACK after the first byte, NACK after the second
  task automatic rd2(input logic [7:0] p, output logic [7:0] d0, d1);
    nak = 1'b0;
    edge_cond(1'b0);
    send({DEVICE_ADDR, 1'b0});
    send(p);
    edge_cond(1'b0);
    send({DEVICE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d0[i]);
    bit_io(1'b0, r);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d1[i]);
    bit_io(1'b1, r);
    edge_cond(1'b1);
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import charge_profile_pkg::*;
  logic       sys_clk, rst_b, scl, sda_drv, sda_out, sda_oe_b, nak;
  logic       reg_reset, battery_below_min, system_loop_slowdown;
  logic [7:0] charge_current, end_of_charge_current, precharge_limit;
  logic [7:0] applied_precharge_current, rv;
  logic [2:0] high_side_two_strength, low_side_two_strength;
  int         n_mismatch = 0;
  int         tests_run = 0;
  wire        sda = sda_drv & (sda_oe_b | sda_out);

  serial_host_model host (.sys_clk, .sda, .scl, .sda_drv, .nak);
  charge_profile_gate_drive_regs DUT (
    .sys_clk, .rst_b, .scl, .sda_in(sda), .sda_out, .sda_oe_b, .reg_reset,
    .charge_current, .battery_below_min, .end_of_charge_current,
    .precharge_limit, .high_side_two_strength, .low_side_two_strength,
    .system_loop_slowdown, .applied_precharge_current
  );
  always #5 sys_clk = ~sys_clk;

  // ==========
  task automatic check(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] rv2;
    check(end_of_charge_current, 8'h20);
    check({7'h00, sda_oe_b}, 8'h01);
    check({7'h00, sda_out}, 8'h00);
    host.rd2(8'h10, rv, rv2);
    check(rv, 8'h20);
    check(rv2, 8'h30);
    host.rd(8'h11, rv);
    check(rv, 8'h30);
    host.rd(8'h12, rv);
    check(rv, 8'h6c);
  endtask
  task automatic t_clamp;
    logic [7:0] w [6] = '{8'h00, 8'h0f, 8'h10, 8'hff, 8'hfc, 8'hfd};
    logic [7:0] e [6] = '{8'h10, 8'h10, 8'h10, 8'hfc, 8'hfc, 8'hfc};
    for (int i = 0; i < 6; i++) begin
      host.wr(DEVICE_ADDR, 8'h10, w[i]);
      check(end_of_charge_current, e[i]);
      host.wr(DEVICE_ADDR, 8'h11, w[5 - i]);
      host.rd(8'h11, rv);
      check(rv, e[5 - i]);
    end
  endtask
  task automatic t_gate;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], 3'(7 - i), i[0], 1'b1};
      host.wr(DEVICE_ADDR, 8'h12, v);
      rv = {high_side_two_strength, low_side_two_strength,
            system_loop_slowdown, 1'b0};
      check(rv, v & 8'hfe);
      host.rd(8'h12, rv);
      check(rv, v & 8'hfe);
    end
  endtask
  task automatic t_regreset;
    host.wr(DEVICE_ADDR, 8'h11, 8'h55);
    host.wr(DEVICE_ADDR, 8'h10, 8'h44);
    @(posedge sys_clk) reg_reset <= 1'b1;
    @(posedge sys_clk) reg_reset <= 1'b0;
    @(negedge sys_clk);
    check(precharge_limit, 8'h30);
    check(end_of_charge_current, 8'h44);
  endtask
  task automatic t_addr;
    host.wr(DEVICE_ADDR ^ 7'h01, 8'h10, 8'h80);
    check({7'h00, nak}, 8'h01);
    check(end_of_charge_current, 8'h44);
    host.wr(DEVICE_ADDR, 8'h13, 8'h77);
    host.rd(8'h13, rv);
    check(rv, 8'h00);
  endtask
  task automatic apply_step(input logic [7:0] cc, input logic bm,
                            input logic [7:0] ex);
    @(posedge sys_clk) charge_current <= cc;
    battery_below_min <= bm;
    repeat (2) @(negedge sys_clk);
    check(applied_precharge_current, ex);
  endtask
  task automatic t_precharge;
    host.wr(DEVICE_ADDR, 8'h11, 8'h40);
    apply_step(8'h3f, 1'b1, 8'h3f);
    apply_step(8'h41, 1'b1, 8'h40);
    apply_step(8'h41, 1'b0, 8'h00);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    reg_reset = 1'b0;
    charge_current = 8'h00;
    battery_below_min = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_clamp();
    t_gate();
    t_regreset();
    t_addr();
    t_precharge();
    finish_test();
  end
endmodule

// ===== verilog/charge_profile_bank.sv
`timescale 1ns/1ps
module charge_profile_bank
  import charge_profile_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Register access
  reg_access_if.bank_side acc,
  // Register-reset command
  input  wire logic       reg_reset,
  // Regulation inputs
  input  wire logic [7:0] charge_current,
  input  wire logic       battery_below_min,
  // Settings
  output logic      [7:0] end_of_charge_current,
  output logic      [7:0] precharge_limit,
  output logic      [2:0] high_side_two_strength,
  output logic      [2:0] low_side_two_strength,
  output logic            system_loop_slowdown,
  output logic      [7:0] applied_precharge_current
);

  // ==========================================================
  // Decode and clamp
  // ==========================================================
  wire       hit_term   = acc.addr == TERM_CURRENT_ADDR;
  wire       hit_prechg = acc.addr == PRECHG_CLAMP_ADDR;
  wire       hit_gate   = acc.addr == GATE_DRIVE_ADDR;
  wire [7:0] clamped    = (acc.wdata < CURRENT_CLAMP_LOW)  ?
                          CURRENT_CLAMP_LOW :
                          (acc.wdata > CURRENT_CLAMP_HIGH) ?
                          CURRENT_CLAMP_HIGH : acc.wdata;
  wire [7:0] gate_read  = {high_side_two_strength, low_side_two_strength,
                           system_loop_slowdown, 1'b0};
  wire [7:0] next_applied = (charge_current < precharge_limit) ?
                            charge_current : precharge_limit;

  assign acc.rdata = hit_term   ? end_of_charge_current :
                     hit_prechg ? precharge_limit :
                     hit_gate   ? gate_read : UNMAPPED_READ;

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      end_of_charge_current <= TERM_CURRENT_RST;
    end else if (acc.wr_en && hit_term) begin
      end_of_charge_current <= clamped;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      precharge_limit <= PRECHG_CLAMP_RST;
    end else if (reg_reset) begin
      precharge_limit <= PRECHG_CLAMP_RST;
    end else if (acc.wr_en && hit_prechg) begin
      precharge_limit <= clamped;
    end
  end

  // Reserved bit 0 of the gate drive write data is dropped
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_side_two_strength <= HIGH_SIDE_RST;
      low_side_two_strength  <= LOW_SIDE_RST;
      system_loop_slowdown   <= SLOWDOWN_RST;
    end else if (acc.wr_en && hit_gate) begin
      high_side_two_strength <= acc.wdata[HIGH_SIDE_MSB:HIGH_SIDE_LSB];
      low_side_two_strength  <= acc.wdata[LOW_SIDE_MSB:LOW_SIDE_LSB];
      system_loop_slowdown   <= acc.wdata[SLOWDOWN_BIT];
    end
  end

  // Applied precharge is zero outside the precharge region
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      applied_precharge_current <= 8'h00;
    end else if (battery_below_min) begin
      applied_precharge_current <= next_applied;
    end else begin
      applied_precharge_current <= 8'h00;
    end
  end

endmodule

// ===== verilog/charge_profile_gate_drive_regs.sv
// Functional notes
// - Termination current register, 8 bits, resets to 20h, 8 mA per step.
// - Current writes below 10h store 10h; above FCh store FCh.
// - Precharge clamp register resets to 30h, also on register-reset.
// - Gate drive bits 7-5 high-side strength code, reset 3h.
// - Gate drive bits 4-2 low-side strength code, reset 3h.
// - Gate drive bit 1 slows system loop when set, reset 0.
// - Termination current at 10h, precharge clamp at 11h.
// - Gate drive register at 12h, reset value 6Ch.
`timescale 1ns/1ps
module charge_profile_gate_drive_regs
  import charge_profile_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Two-wire serial port
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b,
  // Register-reset command
  input  wire logic       reg_reset,
  // Regulation inputs
  input  wire logic [7:0] charge_current,
  input  wire logic       battery_below_min,
  // Settings to the regulation loops
  output logic      [7:0] end_of_charge_current,
  output logic      [7:0] precharge_limit,
  output logic      [2:0] high_side_two_strength,
  output logic      [2:0] low_side_two_strength,
  output logic            system_loop_slowdown,
  output logic      [7:0] applied_precharge_current
);

  import charge_profile_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_PTR,
    ST_ACK_PTR,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_ACK_RDATA
  } port_state_t;

  // ==========================================================
  // Line sampling and bus conditions
  // ==========================================================
  logic scl_q;
  logic sda_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  wire scl_rise   = scl & ~scl_q;
  wire scl_fall   = ~scl & scl_q;
  wire bus_start  = scl & scl_q & sda_q & ~sda_in;
  wire bus_stop   = scl & scl_q & ~sda_q & sda_in;

  // ==========================================================
  // Transaction state
  // ==========================================================
  port_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic [7:0]  shift_out;
  logic [7:0]  pointer;
  logic        write_pulse;
  logic        read_mode;

  reg_access_if acc ();

  assign acc.wr_en = write_pulse;
  assign acc.addr  = pointer;
  assign acc.wdata = shift_in;

  wire byte_done   = bit_cnt == BITS_PER_BYTE;
  wire receiving   = (state == ST_ADDR) || (state == ST_PTR) ||
                     (state == ST_WDATA);
  wire addr_match  = shift_in[7:1] == DEVICE_ADDR;
  wire [7:0] next_pointer = pointer + 8'h01;
  wire next_out_bit = shift_out[3'(4'h7 - bit_cnt)];

  // ==========================================================
  // Byte engine
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      shift_in    <= 8'h00;
      shift_out   <= 8'h00;
      pointer     <= 8'h00;
      write_pulse <= 1'b0;
      read_mode   <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe_b    <= 1'b1;
    end else begin
      write_pulse <= 1'b0;
      sda_out     <= 1'b0;
      if (bus_start) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_b <= 1'b1;
      end else if (bus_stop) begin
        state    <= ST_IDLE;
        sda_oe_b <= 1'b1;
      end else if (scl_rise) begin
        if (receiving) begin
          shift_in <= {shift_in[6:0], sda_in};
          bit_cnt  <= bit_cnt + 4'h1;
        end else if (state == ST_RDATA) begin
          bit_cnt  <= bit_cnt + 4'h1;
        end else if (state == ST_ACK_RDATA && sda_in) begin
          state    <= ST_IDLE;
        end
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (byte_done && addr_match) begin
              state     <= ST_ACK_ADDR;
              read_mode <= shift_in[0];
              sda_oe_b  <= 1'b0;
            end else if (byte_done) begin
              state     <= ST_IDLE;
            end
          end
          ST_PTR: begin
            if (byte_done) begin
              state    <= ST_ACK_PTR;
              pointer  <= shift_in;
              sda_oe_b <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              state       <= ST_ACK_WDATA;
              write_pulse <= 1'b1;
              sda_oe_b    <= 1'b0;
            end
          end
          ST_ACK_ADDR: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              state     <= ST_RDATA;
              shift_out <= acc.rdata;
              sda_oe_b  <= acc.rdata[7];
            end else begin
              state    <= ST_PTR;
              sda_oe_b <= 1'b1;
            end
          end
          ST_ACK_PTR: begin
            state    <= ST_WDATA;
            bit_cnt  <= 4'h0;
            sda_oe_b <= 1'b1;
          end
          ST_ACK_WDATA: begin
            state    <= ST_WDATA;
            bit_cnt  <= 4'h0;
            pointer  <= next_pointer;
            sda_oe_b <= 1'b1;
          end
          ST_RDATA: begin
            if (byte_done) begin
              state    <= ST_ACK_RDATA;
              pointer  <= next_pointer;
              sda_oe_b <= 1'b1;
            end else begin
              sda_oe_b <= next_out_bit;
            end
          end
          ST_ACK_RDATA: begin
            state     <= ST_RDATA;
            bit_cnt   <= 4'h0;
            shift_out <= acc.rdata;
            sda_oe_b  <= acc.rdata[7];
          end
          default: begin
            sda_oe_b <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register bank
  // ==========================================================
  charge_profile_bank u_bank (
    .sys_clk                   (sys_clk),
    .rst_b                     (rst_b),
    .acc                       (acc),
    .reg_reset                 (reg_reset),
    .charge_current            (charge_current),
    .battery_below_min         (battery_below_min),
    .end_of_charge_current     (end_of_charge_current),
    .precharge_limit           (precharge_limit),
    .high_side_two_strength    (high_side_two_strength),
    .low_side_two_strength     (low_side_two_strength),
    .system_loop_slowdown      (system_loop_slowdown),
    .applied_precharge_current (applied_precharge_current)
  );

endmodule

// ===== verilog/charge_profile_pkg.sv
package charge_profile_pkg;

  // ==========================================================
  // Serial port
  // ==========================================================
  // Target address on the serial bus; value is arbitrary
  localparam logic [6:0] DEVICE_ADDR        = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] TERM_CURRENT_ADDR  = 8'h10;
  localparam logic [7:0] PRECHG_CLAMP_ADDR  = 8'h11;
  localparam logic [7:0] GATE_DRIVE_ADDR    = 8'h12;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] TERM_CURRENT_RST   = 8'h20;
  localparam logic [7:0] PRECHG_CLAMP_RST   = 8'h30;
  localparam logic [7:0] GATE_DRIVE_RST     = 8'h6c;
  localparam logic [2:0] HIGH_SIDE_RST      = 3'h3;
  localparam logic [2:0] LOW_SIDE_RST       = 3'h3;
  localparam logic       SLOWDOWN_RST       = 1'b0;

  // ==========================================================
  // Current field limits, 8 mA per step
  // ==========================================================
  localparam logic [7:0] CURRENT_CLAMP_LOW  = 8'h10;
  localparam logic [7:0] CURRENT_CLAMP_HIGH = 8'hfc;

  // ==========================================================
  // Gate drive field positions
  // ==========================================================
  localparam int HIGH_SIDE_MSB = 7;
  localparam int HIGH_SIDE_LSB = 5;
  localparam int LOW_SIDE_MSB  = 4;
  localparam int LOW_SIDE_LSB  = 2;
  localparam int SLOWDOWN_BIT  = 1;
  localparam int RESERVED_BIT  = 0;

endpackage

// ===== verilog/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport port_side (output wr_en, output addr, output wdata, input rdata);
  modport bank_side (input wr_en, input addr, input wdata, output rdata);
endinterface
